//--- inc/clsau_params.svh
// Constants for the cursor layer status flags and the ARGB 4:4:4:4 unpacker.
// Assumes one sys_clk domain and a one-cycle register port with read data a cycle later.
// Contract
// - ARGB4444 pixel: alpha in top nibble, then red, green, blue lowest.
// - Each 32-bit word holds two pixels: first in bits 15:0, next in 31:16.
// - Status bit 2 sets when the layer DMA reports end of transfer.
// - Status bit 3 sets when a transfer descriptor was loaded.
// - Status bit 4 sets when the head-pointer descriptor was loaded.
// - Status bit 5 sets when the DMA reaches end of descriptor list.
// - Status bit 6 sets when the cursor layer detects an overflow.
// - Reading the status register clears all flags not set in that same cycle; writes to it do nothing.
`ifndef CLSAU_PARAMS_SVH
`define CLSAU_PARAMS_SVH
// ==========================================================================
// Register addresses
`define CLSAU_ADDR_STATUS  32'hf8038358
`define CLSAU_ADDR_MASK    32'hf803835c
`define CLSAU_ADDR_CTRL    32'hf8038360
`define CLSAU_ADDR_PIXCNT  32'hf8038364
`define CLSAU_ADDR_WORDCNT 32'hf8038368
`define CLSAU_ADDR_LASTWRD 32'hf803836c
// ==========================================================================
// Status and control fields
`define CLSAU_FLAG_LO      2
`define CLSAU_FLAG_N       5
`define CLSAU_STATUS_USED  32'h0000007c
`define CLSAU_CTRL_EN_BIT  0
`define CLSAU_CTRL_CLR_BIT 1
`define CLSAU_CTRL_USED    32'h00000001
// ==========================================================================
// Reset values
`define CLSAU_STATUS_RST   32'h00000000
`define CLSAU_MASK_RST     32'h00000000
`define CLSAU_CTRL_RST     32'h00000000
`define CLSAU_CNT_RST      32'h00000000
// ==========================================================================
// Pixel layout
`define CLSAU_PIX0_LSB     0
`define CLSAU_PIX1_LSB     16
`define CLSAU_NIB_ALPHA    12
`define CLSAU_NIB_RED      8
`define CLSAU_NIB_GREEN    4
`define CLSAU_NIB_BLUE     0
`endif

//--- inc/clsau_pkg.sv
// Types shared by the cursor layer status and pixel unpack design.
// Assumes clsau_params.svh supplies every number.
package clsau_pkg;
  // ========================================================================
  // Pixel, event and bus carriers
  typedef struct packed {
    logic [3:0] alpha;
    logic [3:0] red;
    logic [3:0] green;
    logic [3:0] blue;
  } clsau_argb_t;

  typedef struct packed {
    logic overflow_flag;
    logic end_of_list;
    logic head_loaded;
    logic descriptor_loaded_flag;
    logic dma_end;
  } clsau_evt_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } clsau_bus_req_t;

  // ========================================================================
  // Unpacker sequencing
  typedef enum logic [1:0] {
    UNP_EMPTY,
    UNP_LOW,
    UNP_HIGH
  } clsau_unp_state_t;
endpackage

//--- hw/clsau_unpack.sv
// Splits 32-bit frame buffer words into two ARGB 4:4:4:4 pixels.
// Assumes valid/ready handshakes on both sides and one clock domain.
`include "clsau_params.svh"
module clsau_unpack
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 enable,
  input  wire logic [31:0]          word_data,
  input  wire logic                 word_valid,
  output logic                      word_ready,
  output clsau_pkg::clsau_argb_t    pix,
  output logic                      pix_valid,
  input  wire logic                 pix_ready
);
  import clsau_pkg::*;

  clsau_unp_state_t state_r;
  logic [15:0]      high_half_r;

  // Field split of one 16-bit pixel
  function automatic clsau_argb_t to_argb(input logic [15:0] h);
    clsau_argb_t p;
    p.alpha = h[`CLSAU_NIB_ALPHA +: 4];
    p.red   = h[`CLSAU_NIB_RED +: 4];
    p.green = h[`CLSAU_NIB_GREEN +: 4];
    p.blue  = h[`CLSAU_NIB_BLUE +: 4];
    return p;
  endfunction

  // Word is taken only when empty; costs a bubble but keeps ready a flop
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_r     <= UNP_EMPTY;
      word_ready  <= 1'b0;
      pix_valid   <= 1'b0;
      pix         <= '0;
      high_half_r <= 16'h0000;
    end
    else
    begin
      unique case (state_r)
        UNP_EMPTY:
        begin
          word_ready <= enable;
          if (word_valid && word_ready)
          begin
            pix         <= to_argb(word_data[`CLSAU_PIX0_LSB +: 16]);
            high_half_r <= word_data[`CLSAU_PIX1_LSB +: 16];
            pix_valid   <= 1'b1;
            word_ready  <= 1'b0;
            state_r     <= UNP_LOW;
          end
        end
        UNP_LOW:
        begin
          if (pix_ready)
          begin
            pix     <= to_argb(high_half_r);
            state_r <= UNP_HIGH;
          end
        end
        UNP_HIGH:
        begin
          if (pix_ready)
          begin
            pix_valid  <= 1'b0;
            word_ready <= enable;
            state_r    <= UNP_EMPTY;
          end
        end
      endcase
    end
  end
endmodule

//--- hw/clsau_top.sv
// Cursor layer interrupt status flags, mask, counters and pixel unpacker.
// Assumes event inputs are one-cycle pulses from the layer DMA and pipeline,
// and a register master that never overlaps read and write strobes.
`include "clsau_params.svh"
module clsau_top
(
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire clsau_pkg::clsau_bus_req_t bus_req,
  output logic [31:0]                  bus_rdata,
  input  wire clsau_pkg::clsau_evt_t   evt,
  input  wire logic [31:0]             word_data,
  input  wire logic                    word_valid,
  output logic                         word_ready,
  output clsau_pkg::clsau_argb_t       pix,
  output logic                         pix_valid,
  input  wire logic                    pix_ready,
  output logic                         irq
);
  import clsau_pkg::*;

  // ========================================================================
  // Declarations
  logic [31:0] status_r;
  logic [31:0] status_nxt;
  logic [31:0] mask_r;
  logic [31:0] mask_nxt;
  logic [31:0] ctrl_r;
  logic [31:0] pixcnt_r;
  logic [31:0] wordcnt_r;
  logic [31:0] lastwrd_r;
  logic [31:0] set_vec;
  logic [31:0] rd_mux;
  logic [`CLSAU_FLAG_N-1:0] evt_vec;
  logic        sel_status;
  logic        sel_mask;
  logic        sel_ctrl;
  logic        sel_pixcnt;
  logic        sel_wordcnt;
  logic        sel_lastwrd;
  logic        rd_status;
  logic        wr_mask;
  logic        wr_ctrl;
  logic        cnt_clear;
  logic        unp_enable;
  logic        word_take;
  logic        pix_take;

  // ========================================================================
  // Address decode
  // Full address compare so aliases inside the window never hit
  assign sel_status  = (bus_req.addr == `CLSAU_ADDR_STATUS);
  assign sel_mask    = (bus_req.addr == `CLSAU_ADDR_MASK);
  assign sel_ctrl    = (bus_req.addr == `CLSAU_ADDR_CTRL);
  assign sel_pixcnt  = (bus_req.addr == `CLSAU_ADDR_PIXCNT);
  assign sel_wordcnt = (bus_req.addr == `CLSAU_ADDR_WORDCNT);
  assign sel_lastwrd = (bus_req.addr == `CLSAU_ADDR_LASTWRD);

  // Strobe qualification
  assign rd_status = bus_req.rd && sel_status;
  assign wr_mask   = bus_req.wr && sel_mask;
  assign wr_ctrl   = bus_req.wr && sel_ctrl;
  assign cnt_clear = wr_ctrl && bus_req.wdata[`CLSAU_CTRL_CLR_BIT];

  // ========================================================================
  // Event mapping onto status bit positions
  assign evt_vec[0] = evt.dma_end;
  assign evt_vec[1] = evt.descriptor_loaded_flag;
  assign evt_vec[2] = evt.head_loaded;
  assign evt_vec[3] = evt.end_of_list;
  assign evt_vec[4] = evt.overflow_flag;

  // One generate slice per status bit; bits outside the flag range stay zero
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++)
    begin : g_flag
      if (gi >= `CLSAU_FLAG_LO && gi < `CLSAU_FLAG_LO + `CLSAU_FLAG_N)
      begin : g_used
        assign set_vec[gi] = evt_vec[gi-`CLSAU_FLAG_LO];
        // Set wins over the read clear so a coinciding event survives
        assign status_nxt[gi] = set_vec[gi] || (status_r[gi] && !rd_status);
      end
      else
      begin : g_unused
        assign set_vec[gi]    = 1'b0;
        assign status_nxt[gi] = 1'b0;
      end
    end
  endgenerate

  // ========================================================================
  // Status register, read-clear, not writable
  // A write to this address falls through every branch and is dropped
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      status_r <= `CLSAU_STATUS_RST;
    end
    else
    begin
      status_r <= status_nxt;
    end
  end

  // ========================================================================
  // Mask register, same layout as status
  assign mask_nxt = wr_mask ? (bus_req.wdata & `CLSAU_STATUS_USED) : mask_r;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      mask_r <= `CLSAU_MASK_RST;
    end
    else
    begin
      mask_r <= mask_nxt;
    end
  end

  // ========================================================================
  // Interrupt output
  // Built from next values so the level tracks status with no extra lag
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(status_nxt & mask_nxt);
    end
  end

  // ========================================================================
  // Control register
  // Clear bit is a command: it acts on the counters and is never stored
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ctrl_r <= `CLSAU_CTRL_RST;
    end
    else if (wr_ctrl)
    begin
      ctrl_r <= bus_req.wdata & `CLSAU_CTRL_USED;
    end
  end

  assign unp_enable = ctrl_r[`CLSAU_CTRL_EN_BIT];

  // ========================================================================
  // Pixel unpacker
  // Disabling stops new words; a word already taken still drains
  clsau_unpack u_unpack
  (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .enable     (unp_enable),
    .word_data  (word_data),
    .word_valid (word_valid),
    .word_ready (word_ready),
    .pix        (pix),
    .pix_valid  (pix_valid),
    .pix_ready  (pix_ready)
  );

  assign word_take = word_valid && word_ready;
  assign pix_take  = pix_valid && pix_ready;

  // ========================================================================
  // Delivered pixel counter
  // A handshake in the clearing cycle still counts, so none go missing
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pixcnt_r <= `CLSAU_CNT_RST;
    end
    else if (cnt_clear)
    begin
      pixcnt_r <= {31'h00000000, pix_take};
    end
    else if (pix_take)
    begin
      pixcnt_r <= pixcnt_r + 32'h00000001;
    end
  end

  // Accepted word counter, cleared together with the pixel counter
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wordcnt_r <= `CLSAU_CNT_RST;
    end
    else if (cnt_clear)
    begin
      wordcnt_r <= {31'h00000000, word_take};
    end
    else if (word_take)
    begin
      wordcnt_r <= wordcnt_r + 32'h00000001;
    end
  end

  // Last accepted word, kept for software inspection of the stream
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      lastwrd_r <= `CLSAU_CNT_RST;
    end
    else if (word_take)
    begin
      lastwrd_r <= word_data;
    end
  end

  // ========================================================================
  // Read data path
  // Status reads the pre-clear value; the clear lands on the same edge
  always_comb
  begin
    rd_mux = 32'h00000000;
    unique case (1'b1)
      sel_status:  rd_mux = status_r & `CLSAU_STATUS_USED;
      sel_mask:    rd_mux = mask_r;
      sel_ctrl:    rd_mux = ctrl_r;
      sel_pixcnt:  rd_mux = pixcnt_r;
      sel_wordcnt: rd_mux = wordcnt_r;
      sel_lastwrd: rd_mux = lastwrd_r;
      default:     rd_mux = 32'h00000000;
    endcase
  end

  // Read data stand one cycle after the strobe and read zero otherwise
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      bus_rdata <= 32'h00000000;
    end
    else if (bus_req.rd)
    begin
      bus_rdata <= rd_mux;
    end
    else
    begin
      bus_rdata <= 32'h00000000;
    end
  end
endmodule

//--- sim/clsau_top_monitor.sv
// Checker for the cursor layer status flags and pixel unpacker.
// Assumes it is bound to clsau_top and sees only its ports.
`include "clsau_params.svh"
module clsau_top_monitor
(
  input wire logic                     sys_clk,
  input wire logic                     rst,
  input wire clsau_pkg::clsau_bus_req_t bus_req,
  input wire logic [31:0]              bus_rdata,
  input wire clsau_pkg::clsau_evt_t    evt,
  input wire logic [31:0]              word_data,
  input wire logic                     word_valid,
  input wire logic                     word_ready,
  input wire clsau_pkg::clsau_argb_t   pix,
  input wire logic                     pix_valid,
  input wire logic                     pix_ready,
  input wire logic                     irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import clsau_pkg::*;
  logic rd_s;
  logic tk;
  // ========================================================================
  // Helpers: status read strobe and word take
  assign rd_s = bus_req.rd && (bus_req.addr == `CLSAU_ADDR_STATUS);
  assign tk   = word_valid && word_ready;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ========================================================================
  // Flags: each event shows in the next status read
  property p_dma; evt.dma_end ##1 rd_s |=> bus_rdata[2]; endproperty
  a_dma: assert property (p_dma) else $error("end of transfer flag lost");
  property p_dsc; evt.descriptor_loaded_flag ##1 rd_s |=> bus_rdata[3]; endproperty
  a_dsc: assert property (p_dsc) else $error("descriptor flag lost");
  property p_head; evt.head_loaded ##1 rd_s |=> bus_rdata[4]; endproperty
  a_head: assert property (p_head) else $error("head flag lost");
  property p_eol; evt.end_of_list ##1 rd_s |=> bus_rdata[5]; endproperty
  a_eol: assert property (p_eol) else $error("end of list flag lost");
  // Set must beat the clearing read, else an overflow slips by unseen
  property p_wins; evt.overflow_flag && rd_s ##1 rd_s |=> bus_rdata[6]; endproperty
  a_wins: assert property (p_wins) else $error("overflow lost at read");
  property p_clr; rd_s && evt == 5'h0 ##1 rd_s |=> bus_rdata == 32'h0; endproperty
  a_clr: assert property (p_clr) else $error("status not cleared");
  property p_irq; rd_s && evt == 5'h0 |=> !irq; endproperty
  a_irq: assert property (p_irq) else $error("irq after clear");
  property p_rsv; $past(rd_s) |-> (bus_rdata & ~`CLSAU_STATUS_USED) == 32'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  // ========================================================================
  // Pixels: low half first, then high half
  property p_lo; tk |=> pix_valid && pix == $past(word_data[15:0]); endproperty
  a_lo: assert property (p_lo) else $error("low pixel wrong");
  property p_hi; tk ##1 pix_ready |=> pix_valid && pix == $past(word_data[31:16], 2);
  endproperty
  a_hi: assert property (p_hi) else $error("high pixel wrong");
  c_b2b: cover property (rd_s ##1 rd_s);
  c_tk: cover property (tk);
  c_irq: cover property (irq);
endmodule

bind clsau_top clsau_top_monitor u_mon
(
  .sys_clk    (sys_clk),
  .rst        (rst),
  .bus_req    (bus_req),
  .bus_rdata  (bus_rdata),
  .evt        (evt),
  .word_data  (word_data),
  .word_valid (word_valid),
  .word_ready (word_ready),
  .pix        (pix),
  .pix_valid  (pix_valid),
  .pix_ready  (pix_ready),
  .irq        (irq)
);

//--- sim/clsau_top_bench.sv
// Self-checking bench for clsau_top: register port, events, pixel stream.
// Assumes a 125 MHz sys_clk and synchronous active-high rst.
`include "clsau_params.svh"
module clsau_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import clsau_pkg::*;
  logic           sys_clk;
  logic           rst;
  clsau_bus_req_t bus_req;
  logic [31:0]    bus_rdata;
  clsau_evt_t     evt;
  logic [31:0]    word_data;
  logic           word_valid;
  logic           word_ready;
  clsau_argb_t    pix;
  logic           pix_valid;
  logic           pix_ready;
  logic           irq;
  int             err_count;
  int             checks;
  localparam logic [31:0] ST = `CLSAU_ADDR_STATUS;
  localparam logic [31:0] MK = `CLSAU_ADDR_MASK;

  clsau_top u_dut
  (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .bus_req    (bus_req),
    .bus_rdata  (bus_rdata),
    .evt        (evt),
    .word_data  (word_data),
    .word_valid (word_valid),
    .word_ready (word_ready),
    .pix        (pix),
    .pix_valid  (pix_valid),
    .pix_ready  (pix_ready),
    .irq        (irq)
  );

  // ========================================================================
  // Clock, compare and verdict
  always #4 sys_clk = ~sys_clk;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task summarize;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ========================================================================
  // Bus, event and stream tasks; all start and end just after an edge
  task wr(input logic [31:0] a, input logic [31:0] d);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Holds rd for two cycles when n > 1 so back-to-back reads need no re-raise
  task rd(input logic [31:0] a, input logic [31:0] x0, input logic [31:0] x1,
          input int n, input clsau_evt_t e);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    evt <= e;
    @(posedge sys_clk);
    evt <= '0;
    if (n < 2)
      bus_req.rd <= 1'b0;
    #1 chk(bus_rdata, x0);
    if (n > 1)
    begin
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      #1 chk(bus_rdata, x1);
    end
    @(posedge sys_clk);
  endtask

  task ev(input clsau_evt_t e);
    evt <= e;
    @(posedge sys_clk);
    evt <= '0;
    @(posedge sys_clk);
  endtask

  task irq_is(input logic x);
    @(negedge sys_clk);
    chk({31'h0, irq}, {31'h0, x});
    @(posedge sys_clk);
  endtask

  // Ready is judged 1 ns after an edge, where it is settled for the next take
  task send(input logic [31:0] w);
    int n;
    n = 0;
    word_data <= w;
    word_valid <= 1'b1;
    #1;
    while (word_ready !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk({31'h0, word_ready}, 32'h1);
    @(posedge sys_clk);
    word_valid <= 1'b0;
  endtask

  // Pixel is compared while it stands, before the edge that consumes it
  task getpix(input logic [15:0] e);
    int n;
    n = 0;
    #1;
    while (!(pix_valid === 1'b1 && pix_ready === 1'b1) && n < 20)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk({31'h0, pix_valid}, 32'h1);
    chk({16'h0, pix}, {16'h0, e});
    @(posedge sys_clk);
  endtask

  // ========================================================================
  // Watchdog: the whole run is about a hundred and ten cycles
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    err_count++;
    summarize;
  end

  // ========================================================================
  // Main sequence
  initial
  begin
    sys_clk = 1'b0;
    rst = 1'b1;
    bus_req = '0;
    evt = '0;
    word_data = 32'h0;
    word_valid = 1'b0;
    pix_ready = 1'b0;
    err_count = 0;
    checks = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(ST, 32'h0, 32'h0, 1, '0);
    rd(32'hf8038370, 32'h0, 32'h0, 1, '0);
    wr(ST, 32'hffffffff);
    rd(ST, 32'h0, 32'h0, 1, '0);
    for (int i = 0; i < 5; i++)
    begin
      ev(5'h1 << i);
      rd(ST, 32'h4 << i, 32'h0, 2, '0);
      rd(ST, 32'h0, 32'h4 << i, 2, 5'h1 << i);
    end
    ev(5'h1f);
    rd(ST, 32'h7c, 32'h0, 2, '0);
    rd(ST, 32'h0, 32'h40, 2, 5'h10);
    wr(MK, 32'h40);
    ev(5'h10);
    irq_is(1'b1);
    wr(MK, 32'h0);
    irq_is(1'b0);
    wr(MK, 32'hffffffff);
    rd(MK, 32'h7c, 32'h0, 1, '0);
    irq_is(1'b1);
    rd(ST, 32'h40, 32'h0, 2, '0);
    irq_is(1'b0);
    wr(`CLSAU_ADDR_CTRL, 32'h1);
    send(32'h1234abcd);
    repeat (3) @(posedge sys_clk);
    pix_ready <= 1'b1;
    getpix(16'habcd);
    getpix(16'h1234);
    send(32'hf0e1d2c3);
    getpix(16'hd2c3);
    getpix(16'hf0e1);
    rd(`CLSAU_ADDR_PIXCNT, 32'h4, 32'h0, 1, '0);
    rd(`CLSAU_ADDR_WORDCNT, 32'h2, 32'h0, 1, '0);
    rd(`CLSAU_ADDR_LASTWRD, 32'hf0e1d2c3, 32'h0, 1, '0);
    wr(`CLSAU_ADDR_CTRL, 32'h3);
    rd(`CLSAU_ADDR_CTRL, 32'h1, 32'h0, 1, '0);
    rd(`CLSAU_ADDR_PIXCNT, 32'h0, 32'h0, 1, '0);
    rd(`CLSAU_ADDR_WORDCNT, 32'h0, 32'h0, 1, '0);
    summarize;
  end
endmodule
